// ===== hdl/parallel_master_port_control.v
// Control register and pin function logic of the parallel master port
`include "parallel_port_map.vh"

module parallel_master_port_control (
    input wire clk,
    input wire rst_b,
    input wire [`PPC_ADDR_W-1:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    input wire idle_mode,
    input wire access_req,
    input wire access_write,
    input wire cs_assert,
    input wire latch_assert,
    input wire be_assert,
    output wire port_active,
    output wire [1:0] addr_data_mux_select,
    output wire addr_on_data_low,
    output wire addr_on_data_high,
    output wire cs_is_address,
    output wire access_grant,
    output wire byte_enable_pin_out,
    output wire byte_enable_pin_oe_b,
    output wire write_enable_strobe_pin_out,
    output wire write_enable_strobe_pin_oe_b,
    output wire read_rw_strobe_pin_out,
    output wire read_rw_strobe_pin_oe_b,
    output wire chip_select1_pin_out,
    output wire chip_select1_pin_oe_b,
    output wire addr_latch_low_pin_out,
    output wire addr_latch_low_pin_oe_b
);

    reg [15:0] parallel_port_control_ff;
    reg [15:0] nxt_rdata;
    wire port_enable;
    wire stop_in_idle;
    wire [1:0] chip_select_function;
    wire mux_reserved;
    wire cs1_sel;
    wire latch_used;
    wire strobe_read;
    wire strobe_write;

    // ============================================================
    // Control register
    // Writes keep only implemented bits; reset clears everything
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            parallel_port_control_ff <= `PPC_RESET;
        end else if (reg_wr && reg_addr == `PPC_CTRL_ADDR) begin
            parallel_port_control_ff <= reg_wdata & `PPC_WMASK;
        end
    end

    // ============================================================
    // Read path: data stands in the cycle after the read strobe
    always @* begin
        nxt_rdata = 16'h0000;
        case (reg_addr)
            `PPC_CTRL_ADDR: nxt_rdata = parallel_port_control_ff & `PPC_WMASK;
            `PPC_STAT_ADDR: nxt_rdata = {13'h0000, mux_reserved, access_grant, port_active};
            default: nxt_rdata = 16'h0000;
        endcase
    end

    // Read data register, zero outside read answers
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= nxt_rdata;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ============================================================
    // Field decode
    assign port_enable = parallel_port_control_ff[`PPC_EN_BIT];
    assign stop_in_idle = parallel_port_control_ff[`PPC_SIDL_BIT];
    assign addr_data_mux_select = parallel_port_control_ff[`PPC_MUX_HI:`PPC_MUX_LO];
    assign chip_select_function = parallel_port_control_ff[`PPC_CSF_HI:`PPC_CSF_LO];

    // Port runs when enabled, unless idle with stop-in-idle set
    assign port_active = port_enable && !(stop_in_idle && idle_mode);
    assign access_grant = port_active && access_req;

    // Multiplexing layout flags
    assign mux_reserved = (addr_data_mux_select == 2'h3);
    assign addr_on_data_low = (addr_data_mux_select == `PPC_MUX_LOW8) ||
                              (addr_data_mux_select == `PPC_MUX_FULL);
    assign addr_on_data_high = (addr_data_mux_select == `PPC_MUX_FULL);

    // Chip-select pin is chip select only at code 10, else an address line
    assign cs1_sel = (chip_select_function == `PPC_CSF_CS1);
    assign cs_is_address = !cs1_sel;
    // Address latch is used only when the address is multiplexed
    assign latch_used = addr_on_data_low;

    assign strobe_write = access_grant && access_write;
    assign strobe_read = access_grant && !access_write;

    // ============================================================
    // Pin slots; every strobe-type pin has its own polarity and enable stage
    localparam NUM_PINS = 5;
    localparam PIN_BE = 0;
    localparam PIN_WR = 1;
    localparam PIN_RD = 2;
    localparam PIN_CS = 3;
    localparam PIN_AL = 4;

    wire [NUM_PINS-1:0] pin_enable;
    wire [NUM_PINS-1:0] pin_active_high;
    wire [NUM_PINS-1:0] pin_assert;
    wire [NUM_PINS-1:0] pin_level;
    wire [NUM_PINS-1:0] pin_oe_b;

    // A pin is driven only while the port runs and its own function is on
    assign pin_enable[PIN_BE] = port_active && parallel_port_control_ff[`PPC_BE_EN_BIT];
    assign pin_enable[PIN_WR] = port_active && parallel_port_control_ff[`PPC_WR_EN_BIT];
    assign pin_enable[PIN_RD] = port_active && parallel_port_control_ff[`PPC_RD_EN_BIT];
    assign pin_enable[PIN_CS] = port_active && cs1_sel;
    assign pin_enable[PIN_AL] = port_active && latch_used;

    // Polarity per pin, set means active-high
    assign pin_active_high[PIN_BE] = parallel_port_control_ff[`PPC_BEP_BIT];
    assign pin_active_high[PIN_WR] = parallel_port_control_ff[`PPC_WRSP_BIT];
    assign pin_active_high[PIN_RD] = parallel_port_control_ff[`PPC_RDSP_BIT];
    // Address-line use forces pass-through, so the polarity bit has no effect there
    assign pin_active_high[PIN_CS] = parallel_port_control_ff[`PPC_CHIP_SELECT1_POLARITY_BIT] ||
                                     !cs1_sel;
    assign pin_active_high[PIN_AL] = parallel_port_control_ff[`PPC_ALP_BIT] ||
                                     !latch_used;

    // Asserted states wanted by the core, only while an access is granted
    assign pin_assert[PIN_BE] = access_grant && be_assert;
    assign pin_assert[PIN_WR] = strobe_write;
    assign pin_assert[PIN_RD] = strobe_read;
    assign pin_assert[PIN_CS] = access_grant && cs_assert;
    assign pin_assert[PIN_AL] = access_grant && latch_assert;

    // One polarity and enable stage per pin
    genvar pin_idx;
    generate
        for (pin_idx = 0; pin_idx < NUM_PINS; pin_idx = pin_idx + 1) begin : g_pin
            pin_polarity u_stage (
                .enable(pin_enable[pin_idx]),
                .active_high(pin_active_high[pin_idx]),
                .assert_in(pin_assert[pin_idx]),
                .level_out(pin_level[pin_idx]),
                .oe_b(pin_oe_b[pin_idx])
            );
        end
    endgenerate

    // Pin outputs taken from their slots
    assign byte_enable_pin_out = pin_level[PIN_BE];
    assign byte_enable_pin_oe_b = pin_oe_b[PIN_BE];
    assign write_enable_strobe_pin_out = pin_level[PIN_WR];
    assign write_enable_strobe_pin_oe_b = pin_oe_b[PIN_WR];
    assign read_rw_strobe_pin_out = pin_level[PIN_RD];
    assign read_rw_strobe_pin_oe_b = pin_oe_b[PIN_RD];
    assign chip_select1_pin_out = pin_level[PIN_CS];
    assign chip_select1_pin_oe_b = pin_oe_b[PIN_CS];
    assign addr_latch_low_pin_out = pin_level[PIN_AL];
    assign addr_latch_low_pin_oe_b = pin_oe_b[PIN_AL];

endmodule

// ===== hdl/parallel_port_map.vh
// Register map, field positions and reset values of the parallel port control block
`ifndef PARALLEL_PORT_MAP_VH
`define PARALLEL_PORT_MAP_VH

// ============================================================
// Register offsets
`define PPC_CTRL_ADDR 4'h0
`define PPC_STAT_ADDR 4'h1
`define PPC_ADDR_W 4

// ============================================================
// Control register field positions
`define PPC_EN_BIT 15
`define PPC_SIDL_BIT 13
`define PPC_MUX_HI 12
`define PPC_MUX_LO 11
`define PPC_BE_EN_BIT 10
`define PPC_WR_EN_BIT 9
`define PPC_RD_EN_BIT 8
`define PPC_CSF_HI 7
`define PPC_CSF_LO 6
`define PPC_ALP_BIT 5
`define PPC_CHIP_SELECT1_POLARITY_BIT 3
`define PPC_BEP_BIT 2
`define PPC_WRSP_BIT 1
`define PPC_RDSP_BIT 0

// ============================================================
// Write mask, reset value and codes
`define PPC_WMASK 16'hbfef
`define PPC_RESET 16'h0000
`define PPC_MUX_SEP 2'h0
`define PPC_MUX_LOW8 2'h1
`define PPC_MUX_FULL 2'h2
`define PPC_CSF_CS1 2'h2

`endif

// ===== hdl/pin_polarity.v
// Polarity and enable stage for one strobe-type output pin
module pin_polarity (
    input wire enable,
    input wire active_high,
    input wire assert_in,
    output wire level_out,
    output wire oe_b
);

    // ============================================================
    // Level is the asserted state mapped through the polarity bit
    assign level_out = active_high ? assert_in : ~assert_in;
    // Pin driven only when enabled (oe_b low means driving)
    assign oe_b = ~enable;

endmodule

// ===== verification/ext_port_dev.sv
// Behavioural model of the external device watching the write strobe
module ext_port_dev (
    input logic clk,
    input logic wr_level,
    input logic wr_oe_b,
    output int wr_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    // Counts cycles with the strobe driven and active low
    initial wr_seen = 0;
    always @(posedge clk) if (!wr_oe_b && !wr_level) wr_seen++;
endmodule

// ===== verification/parallel_master_port_control_tb.sv
// Self-checking bench for the parallel port control block
module parallel_master_port_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_b, reg_wr, reg_rd, idle_mode, access_req, access_write;
    logic cs_assert, latch_assert, be_assert, port_active, access_grant;
    logic addr_on_data_low, addr_on_data_high, cs_is_address;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [1:0] addr_data_mux_select;
    logic be_o, be_oe_b, wr_o, wr_oe_b, rd_o, rd_oe_b, cs_o, cs_oe_b, al_o, al_oe_b;
    int bad_count, num_checks, wr_seen, seen_mark;
    parallel_master_port_control dut_u (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .idle_mode, .access_req, .access_write, .cs_assert,
        .latch_assert, .be_assert, .port_active, .addr_data_mux_select, .addr_on_data_low,
        .addr_on_data_high, .cs_is_address, .access_grant, .byte_enable_pin_out(be_o),
        .byte_enable_pin_oe_b(be_oe_b), .write_enable_strobe_pin_out(wr_o),
        .write_enable_strobe_pin_oe_b(wr_oe_b), .read_rw_strobe_pin_out(rd_o),
        .read_rw_strobe_pin_oe_b(rd_oe_b), .chip_select1_pin_out(cs_o),
        .chip_select1_pin_oe_b(cs_oe_b), .addr_latch_low_pin_out(al_o),
        .addr_latch_low_pin_oe_b(al_oe_b));
    ext_port_dev ext_u (.clk, .wr_level(wr_o), .wr_oe_b, .wr_seen);
    // ============================================================
    // Tasks
    task chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [15:0] d, input logic [5:0] s);
        @(posedge clk);
        {idle_mode, access_req, access_write, cs_assert, latch_assert, be_assert} <= s;
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task report_and_stop;
        if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ============================================================
    // Clock, watchdog and test sequence
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #20000;
        bad_count++;
        report_and_stop;
    end
    initial begin
        {rst_b, reg_wr, reg_rd, idle_mode, access_req, access_write} = 6'h00;
        {cs_assert, latch_assert, be_assert, reg_addr, reg_wdata} = 23'h0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        rd(4'h0, 16'h0000);
        wr(4'h0, 16'hffff, 6'h00);
        wr(4'h7, 16'h0000, 6'h00);
        rd(4'h0, 16'hbfef);
        rd(4'h7, 16'h0000);
        wr(4'h0, 16'h0000, 6'h1c);
        seen_mark = wr_seen;
        repeat (4) @(posedge clk);
        #1 seen_mark = wr_seen - seen_mark;
        chk({port_active, access_grant, wr_oe_b, cs_oe_b, 12'(seen_mark)}, 16'h3000);
        seen_mark = wr_seen;
        wr(4'h0, 16'h8280, 6'h1c);
        chk({port_active, access_grant, wr_oe_b, wr_o, cs_oe_b, rd_oe_b, be_oe_b}, 7'h63);
        @(posedge clk);
        #1 chk(16'(wr_seen > seen_mark), 16'h0001);
        wr(4'h0, 16'h8588, 6'h15);
        chk({rd_oe_b, rd_o, be_oe_b, be_o, wr_oe_b, cs_oe_b, cs_o}, 7'h05);
        wr(4'h0, 16'ha000, 6'h30);
        chk({port_active, access_grant}, 2'b00);
        wr(4'h0, 16'h8000, 6'h30);
        chk({port_active, access_grant}, 2'b11);
        for (int k = 0; k < 4; k++) begin
            wr(4'h0, 16'h8080 | 16'(k << 11), 6'h02);
            chk({addr_data_mux_select, addr_on_data_high, addr_on_data_low, al_oe_b},
                {2'(k), k == 2, k == 1 || k == 2, k == 0 || k == 3});
            chk(16'(cs_is_address), 16'h0000);
        end
        rd(4'h1, 16'h0005);
        wr(4'h0, 16'h8820, 6'h12);
        chk({al_oe_b, al_o}, 2'b01);
        wr(4'h0, 16'h8800, 6'h12);
        chk({al_oe_b, al_o}, 2'b00);
        wr(4'h0, 16'h8020, 6'h12);
        chk({al_oe_b, al_o}, 2'b11);
        wr(4'h0, 16'h8000, 6'h14);
        chk({cs_is_address, cs_o}, 2'b11);
        wr(4'h0, 16'h8008, 6'h14);
        chk({cs_is_address, cs_o}, 2'b11);
        @(posedge clk) rst_b <= 1'b0;
        @(posedge clk) rst_b <= 1'b1;
        #1 chk({port_active, be_oe_b, wr_oe_b, rd_oe_b, cs_oe_b, al_oe_b}, 6'h1f);
        rd(4'h0, 16'h0000);
        report_and_stop;
    end
endmodule

// ===== verification/ppc_props.sv
// Assertion checker for the parallel port control block
module ppc_props (
    input logic clk, rst_b, reg_rd, access_req, port_active, access_grant,
    input logic [15:0] reg_rdata,
    input logic [1:0] addr_data_mux_select,
    input logic addr_on_data_low, addr_on_data_high, cs_is_address,
    input logic chip_select1_pin_oe_b, addr_latch_low_pin_oe_b, byte_enable_pin_oe_b,
    input logic write_enable_strobe_pin_oe_b, read_rw_strobe_pin_oe_b
);
    timeunit 1ns;
    timeprecision 1ps;
    // ============================================================
    // Properties
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_gnt; access_grant == (access_req && port_active); endproperty
    a_gnt: assert property (p_gnt) else $error("grant wrong");
    property p_off; !port_active |-> byte_enable_pin_oe_b; endproperty
    a_off: assert property (p_off) else $error("pin driven while off");
    property p_hi; addr_on_data_high == (addr_data_mux_select == 2'h2); endproperty
    a_hi: assert property (p_hi) else $error("full mux wrong");
    property p_lo; addr_on_data_low == (addr_data_mux_select inside {2'h1, 2'h2}); endproperty
    a_lo: assert property (p_lo) else $error("low mux wrong");
    property p_lat;
        addr_latch_low_pin_oe_b == !(port_active && addr_data_mux_select inside {2'h1, 2'h2});
    endproperty
    a_lat: assert property (p_lat) else $error("latch enable wrong");
    property p_cs; chip_select1_pin_oe_b == !(port_active && !cs_is_address); endproperty
    a_cs: assert property (p_cs) else $error("select enable wrong");
    property p_rd; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
    a_rd: assert property (p_rd) else $error("stray read data");
    property p_rst; $rose(rst_b) |-> !port_active; endproperty
    a_rst: assert property (p_rst) else $error("active after reset");
    property p_woff;
        !port_active |-> write_enable_strobe_pin_oe_b && read_rw_strobe_pin_oe_b;
    endproperty
    a_woff: assert property (p_woff) else $error("strobe driven while off");
    property p_rz; $past(reg_rd) |-> !reg_rdata[14] && !reg_rdata[4]; endproperty
    a_rz: assert property (p_rz) else $error("unimplemented bit read as one");
endmodule
bind parallel_master_port_control ppc_props props_u (.*);
